// *** hdl/dcc_pkg.sv ***
// constants, types and register map of the dual comparator control block
// assumes a 32-bit axi4-lite register bus and an external analog front end
package dcc_pkg;
   localparam int DCC_ADDR_W = 8;
   localparam int DCC_DATA_W = 32;
   localparam int DCC_PINS = 6;
   localparam int DCC_APINS = 4;
   localparam int DCC_SYNC_STAGES = 2;
   // register byte offsets
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] STAT_OFF = 8'h04;
   localparam logic [7:0] MASK_OFF = 8'h08;
   localparam logic [7:0] REFC_OFF = 8'h0c;
   localparam logic [7:0] PORT_OFF = 8'h10;
   // comparator_control fields
   localparam int MODE_LSB = 0;
   localparam int ISW_BIT = 3;
   localparam int RES1_BIT = 6;
   localparam int RES2_BIT = 7;
   localparam logic [2:0] MODE_RST = 3'h0;
   localparam logic ISW_RST = 1'b0;
   localparam logic [1:0] IRQ_RST = 2'h0;
   localparam logic REFC_RST = 1'b0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      MODE_RESET = 3'b000, MODE_ONE_SW = 3'b001, MODE_REF = 3'b010, MODE_COMMON = 3'b011,
      MODE_INDEP = 3'b100, MODE_SINGLE = 3'b101, MODE_OUTPUT = 3'b110, MODE_OFF = 3'b111
   } dcc_mode_t;
   typedef enum logic [2:0] {
      SEL_NONE = 3'b000, SEL_PIN0 = 3'b001, SEL_PIN1 = 3'b010, SEL_PIN2 = 3'b011,
      SEL_PIN3 = 3'b100, SEL_VREF = 3'b101
   } dcc_sel_t;
   typedef struct packed {
      dcc_sel_t p1;
      dcc_sel_t n1;
      dcc_sel_t p2;
      dcc_sel_t n2;
      logic on1;
      logic on2;
      logic drv;
      logic [DCC_APINS-1:0] amask;
   } dcc_cfg_t;
endpackage

// *** hdl/dcc_sync_if.sv ***
// carries raw comparator levels into the synchroniser and the sampled levels back
// assumes one clock domain on both ends
`timescale 1ns/100ps
interface dcc_sync_if #(parameter int W = 2);
   logic [W-1:0] raw;
   logic [W-1:0] synced;
   modport src (output raw, input synced);
   modport sync (input raw, output synced);
endinterface

// *** hdl/dcc_sync.sv ***
// multi-stage level synchroniser for the comparator results
// assumes raw levels are asynchronous, reset is synchronous active high
`timescale 1ns/100ps
module dcc_sync #(
   parameter int STAGES = 2,
   parameter int W = 2
) (
   input wire logic i_clk,
   input wire logic i_rst,
   dcc_sync_if.sync port
);
   logic [W-1:0] stage [STAGES];

   // one stage alone would hand a possibly metastable level straight on
   if (STAGES < 2) begin : g_bad_stages
      $error("dcc_sync needs two stages at least");
   end

   ////////////////////////////////////////////////////////////////////////
   // first stage only feeds the second, nothing else looks at it
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         stage[0] <= '0;
      end else begin
         stage[0] <= port.raw;
      end
   end

   generate
      for (genvar s = 1; s < STAGES; s++) begin : g_stage
         always_ff @(posedge i_clk) begin
            if (i_rst) begin
               stage[s] <= '0;
            end else begin
               stage[s] <= stage[s-1];
            end
         end
      end
   endgenerate

   assign port.synced = stage[STAGES-1];
endmodule

// *** hdl/dcc_top.sv ***
// holds the register slave, input/output selectors, result sampling and interrupt
// assumes an analog front end that compares the selected inputs and returns raw levels
`timescale 1ns/100ps
module dcc_top
   import dcc_pkg::*;
#(
   parameter int SYNC_STAGES = DCC_SYNC_STAGES
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [DCC_ADDR_W-1:0] i_awaddr,
   input wire logic [2:0] i_awprot,
   input wire logic i_wvalid,
   output logic o_wready,
   input wire logic [DCC_DATA_W-1:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   output logic o_bvalid,
   input wire logic i_bready,
   output logic [1:0] o_bresp,
   input wire logic i_arvalid,
   output logic o_arready,
   input wire logic [DCC_ADDR_W-1:0] i_araddr,
   input wire logic [2:0] i_arprot,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic [DCC_DATA_W-1:0] o_rdata,
   output logic [1:0] o_rresp,
   input wire logic i_c1_raw,
   input wire logic i_c2_raw,
   output dcc_sel_t o_c1_pos_sel,
   output dcc_sel_t o_c1_neg_sel,
   output dcc_sel_t o_c2_pos_sel,
   output dcc_sel_t o_c2_neg_sel,
   output logic [1:0] o_cmp_on,
   output logic [DCC_APINS-1:0] o_analog_mask,
   input wire logic [DCC_PINS-1:0] i_pin_dir,
   input wire logic [DCC_PINS-1:0] i_port_out,
   input wire logic [DCC_PINS-1:0] i_pin_in,
   output logic [DCC_PINS-1:0] o_pin_out,
   output logic [DCC_PINS-1:0] o_pin_oe_n,
   output logic [DCC_PINS-1:0] o_port_data,
   output logic o_irq
);

   // refused while elaborating, so no netlist with a single flop stage can exist
   if (SYNC_STAGES < 2) begin : g_bad_stages
      $error("dcc_top needs two synchroniser stages at least");
   end

   ////////////////////////////////////////////////////////////////////////
   // mode decode: input selectors, comparator power and analog pins
   function automatic dcc_cfg_t mode_cfg(input dcc_mode_t m, input logic sw);
      dcc_cfg_t c;
      c = '{SEL_NONE, SEL_NONE, SEL_NONE, SEL_NONE, 1'b0, 1'b0, 1'b0, 4'hf};
      case (m)
         MODE_RESET: begin
            c.amask = 4'hf;
         end
         MODE_ONE_SW: begin
            c = '{SEL_PIN2, sw ? SEL_PIN3 : SEL_PIN0, SEL_PIN2, SEL_PIN1, 1'b1, 1'b1, 1'b0, 4'hf};
         end
         MODE_REF: begin
            c = '{SEL_VREF, sw ? SEL_PIN3 : SEL_PIN0, SEL_VREF, sw ? SEL_PIN2 : SEL_PIN1,
                  1'b1, 1'b1, 1'b0, 4'hf};
         end
         MODE_COMMON: begin
            c = '{SEL_PIN2, SEL_PIN0, SEL_PIN2, SEL_PIN1, 1'b1, 1'b1, 1'b0, 4'h7};
         end
         MODE_INDEP: begin
            c = '{SEL_PIN3, SEL_PIN0, SEL_PIN2, SEL_PIN1, 1'b1, 1'b1, 1'b0, 4'hf};
         end
         MODE_SINGLE: begin
            c = '{SEL_NONE, SEL_NONE, SEL_PIN2, SEL_PIN1, 1'b0, 1'b1, 1'b0, 4'h6};
         end
         MODE_OUTPUT: begin
            c = '{SEL_PIN2, SEL_PIN0, SEL_PIN2, SEL_PIN1, 1'b1, 1'b1, 1'b1, 4'h7};
         end
         MODE_OFF: begin
            c.amask = 4'h0;
         end
         default: begin
            c.amask = 4'hf;
         end
      endcase
      return c;
   endfunction

   // register hit test, shared by the write and read paths
   function automatic logic reg_hit(input logic [DCC_ADDR_W-1:0] a);
      return (a == CTRL_OFF) || (a == STAT_OFF) || (a == MASK_OFF) || (a == REFC_OFF) ||
             (a == PORT_OFF);
   endfunction

   dcc_mode_t mode;
   logic isw;
   logic ref_on_c2;
   logic [1:0] irq_stat;
   logic [1:0] irq_mask;
   logic [1:0] res;
   logic [1:0] res_prev;
   logic [1:0] ev;
   dcc_cfg_t cfg;
   logic aw_have;
   logic w_have;
   logic [DCC_ADDR_W-1:0] aw_addr;
   logic [DCC_DATA_W-1:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire;
   logic next_aw_have;
   logic next_w_have;
   logic next_rbusy;
   logic rd_take;
   logic wr_lane0;

   ////////////////////////////////////////////////////////////////////////
   // write channel: address and data taken in either order, answer after both
   assign wr_fire = aw_have && w_have && !o_bvalid;
   assign wr_lane0 = wr_fire && w_strb[0];
   assign next_aw_have = wr_fire ? 1'b0 : (aw_have || (o_awready && i_awvalid));
   assign next_w_have = wr_fire ? 1'b0 : (w_have || (o_wready && i_wvalid));

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         o_awready <= 1'b0;
         o_wready <= 1'b0;
      end else begin
         aw_have <= next_aw_have;
         w_have <= next_w_have;
         o_awready <= !next_aw_have;
         o_wready <= !next_w_have;
         if (o_awready && i_awvalid) begin
            aw_addr <= i_awaddr;
         end
         if (o_wready && i_wvalid) begin
            w_data <= i_wdata;
            w_strb <= i_wstrb;
         end
      end
   end

   // write response, unmapped offsets answer slverr
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_bvalid <= 1'b0;
         o_bresp <= RESP_OKAY;
      end else if (wr_fire) begin
         o_bvalid <= 1'b1;
         o_bresp <= reg_hit(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (i_bready) begin
         o_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control register: only mode and switch are writable, results are not
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         mode <= dcc_mode_t'(MODE_RST);
         isw <= ISW_RST;
      end else if (wr_lane0 && aw_addr == CTRL_OFF) begin
         mode <= dcc_mode_t'(w_data[MODE_LSB +: 3]);
         isw <= w_data[ISW_BIT];
      end
   end

   // reference routing bit lets comparator 2 use the reference in any mode that powers comparator 2
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ref_on_c2 <= REFC_RST;
         irq_mask <= IRQ_RST;
      end else if (wr_lane0) begin
         if (aw_addr == REFC_OFF) begin
            ref_on_c2 <= w_data[0];
         end
         if (aw_addr == MASK_OFF) begin
            irq_mask <= w_data[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // selectors follow the decoded mode one cycle later
   assign cfg = mode_cfg(mode, isw);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_c1_pos_sel <= SEL_NONE;
         o_c1_neg_sel <= SEL_NONE;
         o_c2_pos_sel <= SEL_NONE;
         o_c2_neg_sel <= SEL_NONE;
         o_cmp_on <= 2'h0;
         o_analog_mask <= 4'hf;
      end else begin
         o_c1_pos_sel <= cfg.p1;
         o_c1_neg_sel <= cfg.n1;
         o_c2_pos_sel <= (ref_on_c2 && cfg.on2) ? SEL_VREF : cfg.p2;
         o_c2_neg_sel <= cfg.n2;
         o_cmp_on <= {cfg.on2, cfg.on1};
         o_analog_mask <= cfg.amask;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // results: raw levels are asynchronous, so they pass the synchroniser
   dcc_sync_if #(.W(2)) sync_bus ();
   assign sync_bus.raw = {i_c2_raw, i_c1_raw};

   dcc_sync #(
      .STAGES(SYNC_STAGES),
      .W(2)
   ) u_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .port(sync_bus.sync)
   );

   // a powered-down comparator reads low
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         res <= 2'h0;
         res_prev <= 2'h0;
      end else begin
         res <= sync_bus.synced & {cfg.on2, cfg.on1};
         res_prev <= res;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // change events; a set in the clearing cycle wins over the clear
   assign ev = res ^ res_prev;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         irq_stat <= IRQ_RST;
      end else if (wr_lane0 && aw_addr == STAT_OFF) begin
         irq_stat <= (irq_stat & ~w_data[1:0]) | ev;
      end else begin
         irq_stat <= irq_stat | ev;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(irq_stat & irq_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pins: direction always from the direction register, result drive in output mode
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_pin_oe_n <= '1;
         o_pin_out <= '0;
         o_port_data <= '0;
      end else begin
         o_pin_oe_n <= i_pin_dir;
         o_pin_out <= cfg.drv ? {res, i_port_out[3:0]} : i_port_out;
         o_port_data <= i_pin_in & ~{2'b00, cfg.amask};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read channel: one read at a time, data one cycle after the address
   assign rd_take = o_arready && i_arvalid;
   assign next_rbusy = (o_rvalid && !i_rready) || rd_take;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b0;
         o_rdata <= '0;
         o_rresp <= RESP_OKAY;
      end else begin
         o_arready <= !next_rbusy;
         if (rd_take) begin
            o_rvalid <= 1'b1;
            o_rresp <= reg_hit(i_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (i_araddr)
               CTRL_OFF: o_rdata <= {24'h0, res[1], res[0], 2'b00, isw, mode};
               STAT_OFF: o_rdata <= {30'h0, irq_stat};
               MASK_OFF: o_rdata <= {30'h0, irq_mask};
               REFC_OFF: o_rdata <= {31'h0, ref_on_c2};
               PORT_OFF: o_rdata <= {26'h0, o_port_data};
               default: o_rdata <= '0;
            endcase
         end else if (i_rready) begin
            o_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks on the block's own registers and outputs
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   sequence ctrl_write_s;
      wr_lane0 && aw_addr == CTRL_OFF;
   endsequence
   sequence c1_high_s;
      (i_c1_raw && cfg.on1) [*4];
   endsequence
   sequence c1_low_s;
      (!i_c1_raw) [*4];
   endsequence

   mode_write_a: assert property (ctrl_write_s |=>
      mode == $past(w_data[2:0]) ##1 o_cmp_on == {cfg.on2, cfg.on1})
      else $error("mode field not taken from control write");
   // looks forward from a reset edge, so the unset state before the first edge is never judged
   reset_mode_a: assert property (@(posedge i_clk) disable iff (1'b0)
      i_rst |=> mode == MODE_RESET && res == 2'h0)
      else $error("reset did not return mode 000");
   switch_route_a: assert property (mode == MODE_ONE_SW |=>
      o_c1_neg_sel == ($past(isw) ? SEL_PIN3 : SEL_PIN0))
      else $error("input switch routed wrongly");
   ref_mode_a: assert property (mode == MODE_REF |=> o_c1_pos_sel == SEL_VREF && o_c2_pos_sel == SEL_VREF)
      else $error("reference mode not on both inputs");
   ref_any_a: assert property (ref_on_c2 && cfg.on2 |=> o_c2_pos_sel == SEL_VREF)
      else $error("reference not selectable in this mode");
   result_high_a: assert property (c1_high_s |=> res[0])
      else $error("result 1 not high");
   result_low_a: assert property (c1_low_s |=> !res[0])
      else $error("result 1 not low");
   analog_zero_a: assert property (!$past(i_rst) |-> (o_port_data[3:0] & $past(cfg.amask)) == 4'h0)
      else $error("analog pin read non-zero");
   dir_follow_a: assert property (!$past(i_rst) |-> o_pin_oe_n == $past(i_pin_dir))
      else $error("pin enable ignores direction");
   ctrl_read_a: assert property (rd_take && i_araddr == CTRL_OFF |=> o_rvalid && o_rdata[5:4] == 2'b00)
      else $error("reserved control bits not zero");
   event_wins_a: assert property (ev[0] |=> irq_stat[0])
      else $error("change event lost");
endmodule

// *** verif/tb_dual_comparator_control.sv ***
// self-checking bench for the dual comparator control block, axi4-lite master and pin stimulus
// assumes dcc_pkg and all hdl files are compiled first; single 200 mhz clock
`timescale 1ns/100ps
module tb_dual_comparator_control
   import dcc_pkg::*;
;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
   logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic i_c1_raw = 1'b0, i_c2_raw = 1'b0;
   logic [5:0] i_pin_dir = 6'h3f, i_port_out = 6'h00, i_pin_in = 6'h00;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
   logic [1:0] o_bresp, o_rresp, o_cmp_on;
   logic [31:0] o_rdata;
   dcc_sel_t o_c1_pos_sel, o_c1_neg_sel, o_c2_pos_sel, o_c2_neg_sel;
   logic [3:0] o_analog_mask;
   logic [5:0] o_pin_out, o_pin_oe_n, o_port_data;
   int failures = 0;
   int checked = 0;
   int cycles = 0;
   logic [31:0] rq_d[$], rq_m[$];
   logic [1:0] rq_r[$], bq_r[$];

   dcc_top i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_awvalid(i_awvalid), .o_awready(o_awready),
      .i_awaddr(i_awaddr), .i_awprot(3'h0), .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata),
      .i_wstrb(4'hf), .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid),
      .o_arready(o_arready), .i_araddr(i_araddr), .i_arprot(3'h0), .o_rvalid(o_rvalid), .i_rready(i_rready),
      .o_rdata(o_rdata), .o_rresp(o_rresp), .i_c1_raw(i_c1_raw), .i_c2_raw(i_c2_raw),
      .o_c1_pos_sel(o_c1_pos_sel), .o_c1_neg_sel(o_c1_neg_sel), .o_c2_pos_sel(o_c2_pos_sel),
      .o_c2_neg_sel(o_c2_neg_sel), .o_cmp_on(o_cmp_on), .o_analog_mask(o_analog_mask), .i_pin_dir(i_pin_dir),
      .i_port_out(i_port_out), .i_pin_in(i_pin_in), .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n),
      .o_port_data(o_port_data), .o_irq(o_irq));

   ////////////////////////////////////////////////////////////////////////////////
   // clock and hang guard; the ceiling is far above the few hundred cycles the run needs
   always #2.5 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         $display("mismatch at %0t: run timed out", $time);
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // compare tasks, one per kind of result
   task automatic fail_msg(input logic [31:0] got, input logic [31:0] exp);
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
   endtask
   task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) fail_msg(got, exp);
   endtask
   task automatic chk_rd(input logic [31:0] d, input logic [1:0] r);
      logic [31:0] m, e;
      logic [1:0] er;
      checked++;
      if (rq_d.size() == 0) fail_msg(d, 32'h0);
      else begin
         // all three notes leave together so the queues never slip apart
         m = rq_m.pop_front();
         e = rq_d.pop_front();
         er = rq_r.pop_front();
         if (((d & m) !== e) || (r !== er)) fail_msg(d, e);
      end
   endtask
   task automatic chk_b(input logic [1:0] r);
      checked++;
      if (bq_r.size() == 0 || r !== bq_r.pop_front()) fail_msg(32'(r), 32'h0);
   endtask

   // watcher takes the oldest note whenever a response handshake happens
   always @(posedge i_clk) begin
      if (o_rvalid === 1'b1 && i_rready) chk_rd(o_rdata, o_rresp);
      if (o_bvalid === 1'b1 && i_bready) chk_b(o_bresp);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // bus master: address and data offered together, each dropped once taken, no assumed latency
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      bq_r.push_back(er);
      @(posedge i_clk);
      i_awvalid <= 1'b1;
      i_awaddr <= a;
      i_wvalid <= 1'b1;
      i_wdata <= d;
      i_bready <= 1'b1;
      do begin
         @(posedge i_clk);
         if (i_awvalid && o_awready) i_awvalid <= 1'b0;
         if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      end while (o_bvalid !== 1'b1);
      i_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
      rq_d.push_back(e & m);
      rq_m.push_back(m);
      rq_r.push_back(er);
      @(posedge i_clk);
      i_arvalid <= 1'b1;
      i_araddr <= a;
      i_rready <= 1'b1;
      do begin
         @(posedge i_clk);
         if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      end while (o_rvalid !== 1'b1);
      i_rready <= 1'b0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   task automatic tally_and_finish();
      $display("mismatches %0d comparisons %0d", failures, checked);
      if (failures == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic [4:0] i;
      void'($urandom(32'h245422b8));
      settle(5);
      i_rst <= 1'b0;
      i_pin_in <= 6'($urandom) | 6'h0f; // analog pins held high so any leak shows
      i_port_out <= 6'($urandom);
      settle(2);
      chk_pin(32'(o_analog_mask), 32'hf);
      chk_pin(32'(o_cmp_on), 32'h0);
      chk_pin(32'(o_c1_pos_sel), 32'(SEL_NONE));
      chk_pin(32'(o_pin_oe_n), 32'h3f);
      chk_pin(32'(o_irq), 32'h0);
      rd(CTRL_OFF, 32'h0, 32'hffffffff, RESP_OKAY);
      rd(STAT_OFF, 32'h0, 32'hffffffff, RESP_OKAY);
      rd(MASK_OFF, 32'h0, 32'hffffffff, RESP_OKAY);
      rd(REFC_OFF, 32'h0, 32'hffffffff, RESP_OKAY);
      rd(PORT_OFF, {26'h0, i_pin_in[5:4], 4'h0}, 32'hffffffff, RESP_OKAY);
      // unmapped place refuses both ways
      wr(8'h40, 32'h1, RESP_SLVERR);
      rd(8'h40, 32'h0, 32'hffffffff, RESP_SLVERR);
      // every mode with both switch values; upper written ones must not stick
      for (i = 0; i < 16; i++) begin
         wr(CTRL_OFF, {28'hfffffff, i[3:0]}, RESP_OKAY);
         rd(CTRL_OFF, {28'h0, i[3:0]}, 32'hffffffff, RESP_OKAY);
         settle(3);
         if (i[2:0] inside {3'h1, 3'h2}) chk_pin(32'(o_c1_neg_sel), 32'(i[3] ? SEL_PIN3 : SEL_PIN0));
         if (i[2:0] inside {3'h1, 3'h2}) chk_pin(32'(o_c2_neg_sel), 32'((i[3] && i[1]) ? SEL_PIN2 : SEL_PIN1));
         if (i[2:0] == 3'h2) chk_pin(32'({o_c1_pos_sel, o_c2_pos_sel}), 32'({SEL_VREF, SEL_VREF}));
         if (i[2:0] == 3'h0) chk_pin(32'(o_port_data[3:0]), 32'h0);
         if (i[2:0] == 3'h7) chk_pin(32'(o_port_data[3:0]), 32'(i_pin_in[3:0]));
      end
      // reference on comparator 2 outside the reference mode
      wr(REFC_OFF, 32'h1, RESP_OKAY);
      rd(REFC_OFF, 32'h1, 32'hffffffff, RESP_OKAY);
      wr(CTRL_OFF, 32'h4, RESP_OKAY);
      settle(3);
      chk_pin(32'(o_c2_pos_sel), 32'(SEL_VREF));
      wr(REFC_OFF, 32'h0, RESP_OKAY);
      // direction register keeps governing the pins
      i_pin_dir <= 6'($urandom);
      settle(3);
      chk_pin(32'(o_pin_oe_n), 32'(i_pin_dir));
      // results through the synchroniser, sticky status and masked interrupt
      wr(CTRL_OFF, 32'h3, RESP_OKAY);
      wr(STAT_OFF, 32'h3, RESP_OKAY);
      wr(MASK_OFF, 32'h3, RESP_OKAY);
      rd(MASK_OFF, 32'h3, 32'hffffffff, RESP_OKAY);
      i_c1_raw <= 1'b1;
      settle(8);
      chk_pin(32'(o_irq), 32'h1);
      rd(CTRL_OFF, 32'h43, 32'hffffffff, RESP_OKAY);
      rd(STAT_OFF, 32'h1, 32'hffffffff, RESP_OKAY);
      wr(STAT_OFF, 32'h1, RESP_OKAY);
      settle(3);
      chk_pin(32'(o_irq), 32'h0);
      wr(MASK_OFF, 32'h0, RESP_OKAY);
      i_c2_raw <= 1'b1;
      settle(8);
      rd(STAT_OFF, 32'h2, 32'hffffffff, RESP_OKAY);
      chk_pin(32'(o_irq), 32'h0);
      rd(CTRL_OFF, 32'hc3, 32'hffffffff, RESP_OKAY);
      // results routed onto the upper pins
      wr(CTRL_OFF, 32'h6, RESP_OKAY);
      settle(3);
      chk_pin(32'(o_pin_out[5:4]), 32'h3);
      rd(CTRL_OFF, 32'hc6, 32'hffffffff, RESP_OKAY);
      // second reset in mid-run returns to mode 000 with results off
      i_rst <= 1'b1;
      settle(5);
      i_rst <= 1'b0;
      settle(2);
      chk_pin(32'(o_analog_mask), 32'hf);
      rd(CTRL_OFF, 32'h0, 32'hffffffff, RESP_OKAY);
      settle(2);
      tally_and_finish();
   end
endmodule
